// ==== pkg/ebac_defines.svh ====
// offsets, field positions, reset values and timing counts of the aux bus
`ifndef EBAC_DEFINES_SVH
`define EBAC_DEFINES_SVH

// register indices as printed; the byte address is four times the index
`define EBAC_CFG_IDX 8'h8E
`define EBAC_STAT_IDX 8'h8F

// fields of the aux bus configuration register
`define EBAC_LSUP_BIT 0
`define EBAC_EXTSEL_BIT 1
`define EBAC_XRS_LO_BIT 2
`define EBAC_XRS_HI_BIT 3
`define EBAC_STRETCH_BIT 5
`define EBAC_CFG_RST 8'h00

// fields of the status register
`define EBAC_ST_EMU_BIT 0
`define EBAC_ST_ARMED_BIT 1
`define EBAC_ST_BUSY_BIT 2
`define EBAC_ST_STRAP_BIT 3

// latch strobe divider periods and data strobe lengths, in clock periods
`define EBAC_ALE_DIV_X1 3'h6
`define EBAC_ALE_DIV_X2 3'h3
`define EBAC_MOVX_SHORT 6
`define EBAC_MOVX_LONG 30

`endif

// ==== pkg/ebac_pkg.sv ====
// types shared by the aux bus control files
package ebac_pkg;
  // emulation entry states, gray coded along idle -> armed -> active
  typedef enum logic [1:0] {
    EBAC_EM_IDLE = 2'b00,
    EBAC_EM_ARMED = 2'b01,
    EBAC_EM_ACTIVE = 2'b11
  } ebac_emu_state_t;

  // size code of the expanded data ram: 256, 512, 768 or 1024 bytes
  typedef logic [1:0] ebac_expanded_data_ram_size_t;
endpackage

// ==== verilog/ebac_strobe_gen.sv ====
// latch strobe divider and stretchable external data strobes
`timescale 1ns/1ps
`include "ebac_defines.svh"
module ebac_strobe_gen #(
  parameter int SHORT_LEN = `EBAC_MOVX_SHORT,
  parameter int LONG_LEN = `EBAC_MOVX_LONG
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic double_speed,
  input wire logic latch_suppress,
  input wire logic ext_access_req,
  input wire logic movx_rd_req,
  input wire logic movx_wr_req,
  input wire logic movx_stretch,
  output logic latch_pulse,
  output logic rd_strobe_n,
  output logic wr_strobe_n,
  output logic movx_busy
);
  import ebac_pkg::*;

  initial begin
    if (SHORT_LEN < 1 || LONG_LEN < SHORT_LEN || LONG_LEN > 32) begin
      $error("ebac_strobe_gen: strobe lengths out of range");
    end
  end

  logic [2:0] div_cnt_r;
  logic pend_r;
  logic [4:0] len_cnt_r;
  logic active_r;
  logic is_wr_r;
  logic long_r;
  logic [5:0] low_cnt_r;

  // the >= keeps the divider sane when double speed flips mid-period
  wire [2:0] period = double_speed ? `EBAC_ALE_DIV_X2 : `EBAC_ALE_DIV_X1;
  wire tick = div_cnt_r >= (period - 3'h1);
  wire [2:0] div_cnt_nxt = tick ? 3'h0 : div_cnt_r + 3'h1;
  // suppressed strobe still fires for a pending external access
  wire pulse_nxt = tick & (~latch_suppress | pend_r | ext_access_req);
  wire pend_nxt = (pend_r | ext_access_req) & ~tick;

  // a request while a strobe runs is ignored; the core must wait for it
  wire start = ~active_r & (movx_rd_req | movx_wr_req);
  wire [4:0] load_len = movx_stretch ? 5'(LONG_LEN - 1) : 5'(SHORT_LEN - 1);
  wire active_nxt = start | (active_r & (len_cnt_r != 5'h00));
  wire is_wr_nxt = start ? movx_wr_req & ~movx_rd_req : is_wr_r;
  wire [4:0] len_cnt_nxt = start ? load_len :
                           (active_r ? len_cnt_r - 5'h01 : 5'h00);
  wire strobe_low = ~rd_strobe_n | ~wr_strobe_n;

  // latch strobe divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 3'h0;
      pend_r <= 1'b0;
      latch_pulse <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      pend_r <= pend_nxt;
      latch_pulse <= pulse_nxt;
    end
  end

  // data strobe length counter, length fixed at the start of the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= 1'b0;
      is_wr_r <= 1'b0;
      long_r <= 1'b0;
      len_cnt_r <= 5'h00;
      rd_strobe_n <= 1'b1;
      wr_strobe_n <= 1'b1;
    end else begin
      active_r <= active_nxt;
      is_wr_r <= is_wr_nxt;
      long_r <= start ? movx_stretch : long_r;
      len_cnt_r <= len_cnt_nxt;
      rd_strobe_n <= ~(active_nxt & ~is_wr_nxt);
      wr_strobe_n <= ~(active_nxt & is_wr_nxt);
    end
  end

  assign movx_busy = active_r;

  // helper: length of the strobe that is low now
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_r <= 6'h00;
    end else begin
      low_cnt_r <= strobe_low ? low_cnt_r + 6'h01 : 6'h00;
    end
  end

  sequence s_x1_quiet;
    (!double_speed && !latch_suppress) [*5];
  endsequence

  AST_ALE_RATE_X1: assert property (@(posedge pclk) disable iff (!presetn)
    latch_pulse && !double_speed && !latch_suppress ##1 s_x1_quiet
    |=> latch_pulse)
    else $error("latch strobe not every sixth clock");

  AST_ALE_SINGLE: assert property (@(posedge pclk) disable iff (!presetn)
    latch_pulse |=> !latch_pulse)
    else $error("latch strobe longer than one clock");

  AST_ALE_ON_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
    latch_suppress && ext_access_req |-> ##[1:6] latch_pulse)
    else $error("suppressed latch strobe missed an external access");

  AST_MOVX_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(strobe_low) |-> low_cnt_r == (long_r ? LONG_LEN : SHORT_LEN))
    else $error("data strobe length wrong");
endmodule

// ==== verilog/ebac_top.sv ====
// external bus aux control: latch strobe, data strobes, ram select, emulation
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "ebac_defines.svh"
// What this block does
// - latch low through reset release enters emulation
// - emulation releases pins, oscillators kept running
// - only an ordinary reset leaves emulation
// - latch strobe marks address phase on port 0
// - suppress bit stops strobe except external accesses
// - suppressed latch pin released to weak pull-up
// - free latch strobe at clock/6, or /3 doubled
// - data strobes 6 clocks, or 30 when stretched
// - select bit routes data moves internal or external
// - select bit loaded from security byte after power-up
// - reserved bits read zero, software writes zero
module ebac_top #(
  parameter int PADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rst_pin,
  input wire logic latch_strobe_in,
  input wire logic program_store_strobe_in,
  input wire logic core_program_store_strobe,
  input wire logic strap_expanded_data_ram_bit,
  input wire logic double_speed,
  input wire logic ext_access_req,
  input wire logic movx_rd_req,
  input wire logic movx_wr_req,
  input wire logic [15:0] xdata_addr,
  output logic latch_strobe_out,
  output logic latch_strobe_oe,
  output logic program_store_strobe_out,
  output logic program_store_strobe_oe,
  output logic port0_addr_phase,
  output logic movx_rd_n,
  output logic movx_wr_n,
  output logic expanded_data_ram_select,
  output logic emu_mode,
  output logic port0_twi_float,
  output logic ports_weak_pullup,
  output logic osc_hold_on
);
  import ebac_pkg::*;

  initial begin
    if (PADDR_W < 10) begin
      $error("ebac_top: PADDR_W too narrow for the register map");
    end
  end

  // configuration state
  logic latch_suppress_r;
  logic ext_sel_r;
  ebac_expanded_data_ram_size_t expanded_data_ram_size_r;
  logic stretch_r;
  logic strap_loaded_r;
  logic strap_seen_r;
  ebac_emu_state_t em_state_r;
  ebac_emu_state_t em_state_nxt;

  // strobe generator outputs
  logic sg_latch_pulse;
  logic sg_rd_n;
  logic sg_wr_n;
  logic sg_busy;

  // ---------------------------------------------------------------
  // apb decode; the slave answers in the first access cycle
  wire [PADDR_W-1:0] cfg_addr = PADDR_W'({`EBAC_CFG_IDX, 2'b00});
  wire [PADDR_W-1:0] stat_addr = PADDR_W'({`EBAC_STAT_IDX, 2'b00});
  wire hit_cfg = paddr == cfg_addr;
  wire hit_stat = paddr == stat_addr;
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable & pready;
  // status register is read only; writing it is refused like a miss
  wire apb_bad = ~(hit_cfg | (hit_stat & ~pwrite));
  wire wr_cfg = apb_access & pwrite & hit_cfg;

  // read views; reserved bits read as zero, software keeps them zero
  wire [7:0] cfg_view = {2'b00, stretch_r, 1'b0, expanded_data_ram_size_r,
                         ext_sel_r, latch_suppress_r};
  wire [7:0] stat_view = {4'h0, strap_seen_r, sg_busy,
                          em_state_r == EBAC_EM_ARMED,
                          em_state_r == EBAC_EM_ACTIVE};
  wire [31:0] rd_mux = hit_cfg ? {24'h000000, cfg_view} :
                       (hit_stat ? {24'h000000, stat_view} : 32'h00000000);

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & apb_bad;
      prdata <= (apb_setup & ~pwrite) ? rd_mux : prdata;
    end
  end

  // ---------------------------------------------------------------
  // configuration register; the ram select bit is a strap caught a single
  // time, on the first edge after reset release, never inside the reset
  wire ext_sel_nxt = !strap_loaded_r ? ~strap_expanded_data_ram_bit :
                     (wr_cfg ? pwdata[`EBAC_EXTSEL_BIT] : ext_sel_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_suppress_r <= 1'(`EBAC_CFG_RST >> `EBAC_LSUP_BIT);
      ext_sel_r <= 1'b0;
      expanded_data_ram_size_r <= 2'b00;
      stretch_r <= 1'b0;
      strap_loaded_r <= 1'b0;
      strap_seen_r <= 1'b0;
    end else begin
      strap_loaded_r <= 1'b1;
      strap_seen_r <= strap_loaded_r ? strap_seen_r : strap_expanded_data_ram_bit;
      ext_sel_r <= ext_sel_nxt;
      if (wr_cfg) begin
        latch_suppress_r <= pwdata[`EBAC_LSUP_BIT];
        expanded_data_ram_size_r <= pwdata[`EBAC_XRS_HI_BIT:`EBAC_XRS_LO_BIT];
        stretch_r <= pwdata[`EBAC_STRETCH_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // emulation entry: armed while reset pin is high, latch pin low and
  // program store pin high; entered if latch is still low at release
  wire entry_cond = ~latch_strobe_in & program_store_strobe_in;

  always_comb begin
    em_state_nxt = em_state_r;
    case (em_state_r)
      EBAC_EM_IDLE: begin
        if (rst_pin && entry_cond) begin
          em_state_nxt = EBAC_EM_ARMED;
        end
      end
      EBAC_EM_ARMED: begin
        if (rst_pin && !entry_cond) begin
          em_state_nxt = EBAC_EM_IDLE;
        end else if (!rst_pin) begin
          em_state_nxt = latch_strobe_in ? EBAC_EM_IDLE : EBAC_EM_ACTIVE;
        end
      end
      EBAC_EM_ACTIVE: begin
        // any reset pin pulse ends emulation; re-entry needs the sequence
        if (rst_pin) begin
          em_state_nxt = entry_cond ? EBAC_EM_ARMED : EBAC_EM_IDLE;
        end
      end
      default: begin
        em_state_nxt = EBAC_EM_IDLE;
      end
    endcase
  end

  wire emu_nxt = em_state_nxt == EBAC_EM_ACTIVE;

  // emulation state and the pin release outputs that follow it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      em_state_r <= EBAC_EM_IDLE;
      emu_mode <= 1'b0;
      port0_twi_float <= 1'b0;
      ports_weak_pullup <= 1'b0;
      osc_hold_on <= 1'b0;
    end else begin
      em_state_r <= em_state_nxt;
      emu_mode <= emu_nxt;
      port0_twi_float <= emu_nxt;
      ports_weak_pullup <= emu_nxt;
      osc_hold_on <= emu_nxt;
    end
  end

  // ---------------------------------------------------------------
  // strobe timing lives in its own module
  ebac_strobe_gen #(
    .SHORT_LEN(`EBAC_MOVX_SHORT),
    .LONG_LEN(`EBAC_MOVX_LONG)
  ) u_strobe (
    .pclk(pclk),
    .presetn(presetn),
    .double_speed(double_speed),
    .latch_suppress(latch_suppress_r),
    .ext_access_req(ext_access_req),
    .movx_rd_req(movx_rd_req),
    .movx_wr_req(movx_wr_req),
    .movx_stretch(stretch_r),
    .latch_pulse(sg_latch_pulse),
    .rd_strobe_n(sg_rd_n),
    .wr_strobe_n(sg_wr_n),
    .movx_busy(sg_busy)
  );

  // latch pin is driven only while not released; when suppressed it is
  // driven just for its pulse, so outside that the weak pull-up holds it;
  // with the reset pin high it is let go too, else our own low level
  // between pulses would arm emulation entry without any outside party
  wire latch_oe_nxt = ~emu_nxt & ~rst_pin &
                      (~latch_suppress_r | sg_latch_pulse);
  wire pss_oe_nxt = ~emu_nxt;

  // expanded ram hit: top six address bits clear and page within size
  wire in_size = (xdata_addr[15:10] == 6'h00) &
                 (xdata_addr[9:8] <= expanded_data_ram_size_r);
  wire expanded_data_ram_nxt = ~ext_sel_r & in_size;

  // pin side registers; strobes park high while the pins are released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_strobe_out <= 1'b1;
      latch_strobe_oe <= 1'b0;
      program_store_strobe_out <= 1'b1;
      program_store_strobe_oe <= 1'b0;
      port0_addr_phase <= 1'b0;
      movx_rd_n <= 1'b1;
      movx_wr_n <= 1'b1;
      expanded_data_ram_select <= 1'b0;
    end else begin
      latch_strobe_out <= latch_oe_nxt ? sg_latch_pulse : 1'b1;
      latch_strobe_oe <= latch_oe_nxt;
      program_store_strobe_out <= pss_oe_nxt ? core_program_store_strobe :
                                  1'b1;
      program_store_strobe_oe <= pss_oe_nxt;
      port0_addr_phase <= sg_latch_pulse & ~emu_nxt;
      movx_rd_n <= sg_rd_n | emu_nxt;
      movx_wr_n <= sg_wr_n | emu_nxt;
      expanded_data_ram_select <= expanded_data_ram_nxt;
    end
  end

  // ---------------------------------------------------------------
  // checks on the emulation sequence and the pin side
  sequence s_armed_release;
    em_state_r == EBAC_EM_ARMED && !rst_pin && !latch_strobe_in;
  endsequence

  sequence s_pins_released;
    !latch_strobe_oe && !program_store_strobe_oe && ports_weak_pullup
      && port0_twi_float && osc_hold_on;
  endsequence

  AST_EMU_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    s_armed_release |=> emu_mode ##0 s_pins_released)
    else $error("emulation not entered at reset release");

  AST_EMU_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
    emu_mode |-> s_pins_released)
    else $error("pins driven during emulation");

  AST_EMU_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(emu_mode) |-> $past(rst_pin))
    else $error("emulation left without a reset");

  AST_LATCH_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    latch_strobe_out && latch_strobe_oe |-> port0_addr_phase)
    else $error("latch strobe without address phase");

  AST_LATCH_WEAK: assert property (@(posedge pclk) disable iff (!presetn)
    $past(latch_suppress_r) && !$past(sg_latch_pulse)
      |-> !latch_strobe_oe && latch_strobe_out)
    else $error("suppressed latch pin driven low");

  AST_LATCH_FREE: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) && !$past(rst_pin) && !$past(latch_suppress_r)
      && !emu_mode |-> latch_strobe_oe)
    else $error("free latch strobe not driven");

  AST_EXPANDED_DATA_RAM_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
    ext_sel_r |=> !expanded_data_ram_select)
    else $error("external select still routes on chip");

  AST_EXPANDED_DATA_RAM_SIZE: assert property (@(posedge pclk) disable iff (!presetn)
    !ext_sel_r && xdata_addr[15:8] == {6'h00, expanded_data_ram_size_r} |=> expanded_data_ram_select)
    else $error("top page of the selected size not on chip");

  AST_SEC_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strap_loaded_r) |-> ext_sel_r == ~$past(strap_expanded_data_ram_bit))
    else $error("select bit not loaded from security byte");

  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && hit_cfg |-> prdata[7:6] == 2'b00 && !prdata[4])
    else $error("reserved bits read nonzero");
endmodule

// ==== verification/ebac_emu_model.sv ====
// emulator or tester standing on the latch and program store strobe pins
`timescale 1ns/1ps
module ebac_emu_model (
  input wire logic hold_latch_low,
  input wire logic latch_strobe_out,
  input wire logic latch_strobe_oe,
  input wire logic program_store_strobe_out,
  input wire logic program_store_strobe_oe,
  output logic latch_strobe_in,
  output logic program_store_strobe_in
);
  // the emulator pulls the latch pin low hard enough to win; a released
  // pin settles high through its weak pull-up
  assign latch_strobe_in = hold_latch_low ? 1'b0 :
    (latch_strobe_oe ? latch_strobe_out : 1'b1);
  // program store strobe is left alone, so entry sees it high
  assign program_store_strobe_in = program_store_strobe_oe ?
    program_store_strobe_out : 1'b1;
endmodule

// ==== verification/tb_external_bus_aux_control.sv ====
// register, strobe, ram select and emulation entry tests of the aux bus
`timescale 1ns/1ps
module tb_external_bus_aux_control;
  import ebac_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rst_pin, lat_in, pss_in, strap, dsp, ext_req, rd_req, wr_req;
  logic [15:0] xaddr;
  logic lat_out, lat_oe, pss_out, pss_oe, p0_phase, rd_n, wr_n, xsel;
  logic emu, p0_float, weak_pu, osc_on, hold_low, err, core_pss;
  int n_errors, n_tests, g, c;
  localparam logic [11:0] CFG = 12'h238;
  localparam logic [11:0] STAT = 12'h23C;

  ebac_top #(.PADDR_W(12)) ebac_top_inst (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rst_pin(rst_pin), .latch_strobe_in(lat_in),
    .program_store_strobe_in(pss_in), .core_program_store_strobe(core_pss),
    .strap_expanded_data_ram_bit(strap), .double_speed(dsp), .ext_access_req(ext_req),
    .movx_rd_req(rd_req), .movx_wr_req(wr_req), .xdata_addr(xaddr),
    .latch_strobe_out(lat_out), .latch_strobe_oe(lat_oe),
    .program_store_strobe_out(pss_out), .program_store_strobe_oe(pss_oe),
    .port0_addr_phase(p0_phase), .movx_rd_n(rd_n), .movx_wr_n(wr_n),
    .expanded_data_ram_select(xsel), .emu_mode(emu), .port0_twi_float(p0_float),
    .ports_weak_pullup(weak_pu), .osc_hold_on(osc_on));

  ebac_emu_model ebac_emu_model_inst (.hold_latch_low(hold_low),
    .latch_strobe_out(lat_out), .latch_strobe_oe(lat_oe),
    .program_store_strobe_out(pss_out), .program_store_strobe_oe(pss_oe),
    .latch_strobe_in(lat_in), .program_store_strobe_in(pss_in));

  // free-running 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task complete_run;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; waits for pready, never a fixed count
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= wr; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    check("pready wait", 32'd1, k);
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      complete_run();
    end
  endtask

  // a wait that runs out is a mismatch and ends the run
  task limit(input logic hit);
    if (hit) begin
      n_errors++;
      complete_run();
    end
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    check("read data", exp, rd);
    check("read error", {31'h0, e}, {31'h0, err});
  endtask

  // cycles between two latch pulses; address phase must mark the first pulse
  task lgap;
    int k;
    k = 0;
    while (lat_out !== 1'b1 && k < 40) begin @(posedge pclk); k++; end
    limit(lat_out !== 1'b1);
    check("address phase", 32'h1, {31'h0, p0_phase});
    @(posedge pclk);
    g = 1;
    while (lat_out !== 1'b1 && g < 40) begin @(posedge pclk); g++; end
    limit(lat_out !== 1'b1);
  endtask

  // one data strobe request; g returns the low time of the strobe
  task strobe(input logic wr);
    int k;
    @(posedge pclk); rd_req <= ~wr; wr_req <= wr;
    @(posedge pclk); rd_req <= 1'b0; wr_req <= 1'b0;
    k = 0;
    while ((wr ? wr_n : rd_n) !== 1'b0 && k < 10) begin
      @(posedge pclk); k++;
    end
    g = 0;
    while ((wr ? wr_n : rd_n) === 1'b0 && g < 40) begin
      @(posedge pclk); g++;
    end
    limit(g >= 40);
  endtask

  initial begin
    n_errors = 0; n_tests = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; rst_pin = 1'b0; strap = 1'b1;
    dsp = 1'b0; ext_req = 1'b0; rd_req = 1'b0; wr_req = 1'b0;
    xaddr = 16'h0000; hold_low = 1'b0;
    core_pss = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    // reset values, unmapped place and read-only status
    rdchk(CFG, 32'h0, 1'b0);
    rdchk(STAT, 32'h08, 1'b0);
    rdchk(12'h100, 32'h0, 1'b1);
    apb(1'b1, STAT, 32'h01);
    check("status write error", 32'h1, {31'h0, err});
    apb(1'b1, CFG, 32'h2C);
    rdchk(CFG, 32'h2C, 1'b0);
    apb(1'b1, CFG, 32'h00);
    // continuous latch strobe at both rates
    lgap();
    check("latch period x1", 32'd6, g);
    check("latch driven", 32'h1, {31'h0, lat_oe});
    @(posedge pclk); dsp <= 1'b1;
    repeat (8) @(posedge pclk);
    lgap();
    check("latch period x2", 32'd3, g);
    @(posedge pclk); dsp <= 1'b0;
    // suppressed strobe: released pin, pulse only for an external access
    apb(1'b1, CFG, 32'h01);
    repeat (8) @(posedge pclk);
    for (c = 0; c < 12; c++) begin
      @(posedge pclk);
      check("suppressed oe", 32'h0, {31'h0, lat_oe});
      check("suppressed pin", 32'h1, {31'h0, lat_in});
      check("no phase", 32'h0, {31'h0, p0_phase});
    end
    @(posedge pclk); ext_req <= 1'b1;
    @(posedge pclk); ext_req <= 1'b0;
    g = 0;
    while (p0_phase !== 1'b1 && g < 10) begin @(posedge pclk); g++; end
    limit(p0_phase !== 1'b1);
    check("external access pulse", 32'h1, {31'h0, p0_phase});
    check("pulse level", 32'h1, {31'h0, lat_out});
    // data strobe lengths, plain and stretched
    apb(1'b1, CFG, 32'h00);
    strobe(1'b0);
    check("read strobe short", 32'd6, g);
    apb(1'b1, CFG, 32'h20);
    strobe(1'b1);
    check("write strobe long", 32'd30, g);
    // every size code at its boundary, then the external select
    for (c = 0; c < 4; c++) begin
      apb(1'b1, CFG, c << 2);
      @(posedge pclk); xaddr <= 16'((c + 1) * 256 - 1);
      repeat (3) @(posedge pclk);
      check("last on-chip byte", 32'h1, {31'h0, xsel});
      xaddr <= 16'((c + 1) * 256);
      repeat (3) @(posedge pclk);
      check("first external byte", 32'h0, {31'h0, xsel});
    end
    xaddr <= 16'h0000;
    apb(1'b1, CFG, 32'h02);
    repeat (2) @(posedge pclk);
    check("external select", 32'h0, {31'h0, xsel});
    apb(1'b1, CFG, 32'h00);
    repeat (2) @(posedge pclk);
    check("internal select", 32'h1, {31'h0, xsel});
    // emulation entry through the pin sequence
    rst_pin <= 1'b1; hold_low <= 1'b1;
    repeat (4) @(posedge pclk);
    rdchk(STAT, 32'h0A, 1'b0);
    rst_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    hold_low <= 1'b0;
    // core wants a low strobe; the released pin must still read high
    core_pss <= 1'b0;
    repeat (20) @(posedge pclk);
    check("emulation", 32'h1, {31'h0, emu});
    check("release", 32'h7, {29'h0, p0_float, weak_pu, osc_on});
    check("pins released", 32'h0, {30'h0, lat_oe, pss_oe});
    check("pins pulled", 32'h3, {30'h0, lat_in, pss_in});
    strobe(1'b0);
    check("strobe held off", 32'h0, g);
    // ordinary reset on the pin leaves emulation
    @(posedge pclk); rst_pin <= 1'b1;
    repeat (3) @(posedge pclk); rst_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    check("emulation left", 32'h0, {31'h0, emu});
    check("latch driven again", 32'h1, {31'h0, lat_oe});
    check("program strobe driven", 32'h0, {31'h0, pss_out});
    core_pss <= 1'b1;
    // second reset with the security byte bit programmed
    presetn <= 1'b0; strap <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdchk(CFG, 32'h02, 1'b0);
    rdchk(STAT, 32'h00, 1'b0);
    complete_run();
  end
endmodule
